// File: rtl/ftcan_ctrl_regs.vh
`ifndef FTCAN_CTRL_REGS_VH
`define FTCAN_CTRL_REGS_VH
// Register byte offsets.
`define MODE_CTRL_OFS      12'h000
`define MODE_STAT_OFS      12'h004
`define FAIL_STAT_OFS      12'h008
// Field positions in the status register.
`define STAT_MODE_LSB      0
`define STAT_BATT_BIT      3
`define STAT_WAKE_BIT      4
`define STAT_TXTO_BIT      5
`define STAT_VDDOK_BIT     6
// Mode control reset value (both pins low).
`define MODE_CTRL_RST      2'h0
// Timing figures, ns and us, and cycle counts at 10 ns per cycle.
`define CLK_PERIOD_NS      10
`define TXD_TIMEOUT_US     2000
`define TXD_TIMEOUT_CYC    200000
`define GTS_HOLD_US        4
`define GTS_HOLD_CYC       400
`define F3_DET_US          10
`define F3_DET_CYC         1000
`define F6_DET_US          50
`define F6_DET_CYC         5000
`define F6_REC_US          150
`define F6_REC_CYC         15000
`define F478_DET_US        750
`define F478_DET_CYC       75000
`define FREC_US            10
`define FREC_CYC           1000
`define WAKE_US            8
`define WAKE_CYC           800
`define EDGE_DIFF          3
`endif

// File: rtl/ftcan_ctrl.v
`timescale 1ns/100ps
`include "ftcan_ctrl_regs.vh"

module ftcan_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        txd_in,
  output reg         rxd_out,
  output reg         error_flag_n,
  output wire        regulator_inhibit_out,
  output wire        regulator_inhibit_oe,
  input  wire        vdd_ok_in,
  input  wire        vbat_low_in,
  input  wire        wake_pin_in,
  input  wire        canh_dom_in,
  input  wire        canl_dom_in,
  input  wire        diff_dom_in,
  input  wire        canh_bat_in,
  input  wire        canl_bat_in,
  input  wire        canl_gnd_in,
  input  wire        canh_vdd_in,
  output wire        canh_drv_on,
  output wire        canl_drv_on,
  output wire        canh_term_on,
  output wire        canl_term_vdd,
  output wire        canl_term_bat,
  output wire        rx_enable
);

  localparam [2:0] ST_NORMAL = 3'h0;
  localparam [2:0] ST_RXONLY = 3'h1;
  localparam [2:0] ST_STBY   = 3'h2;
  localparam [2:0] ST_GTS    = 3'h3;
  localparam [2:0] ST_SLEEP  = 3'h4;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers: every analog or pin input passes two flops.
  localparam NSYNC = 11;
  wire [NSYNC-1:0] raw_in;
  reg  [NSYNC-1:0] sync1_q;
  reg  [NSYNC-1:0] sync2_q;
  assign raw_in = {txd_in, vdd_ok_in, vbat_low_in, wake_pin_in,
                   canh_dom_in, canl_dom_in, diff_dom_in, canh_bat_in,
                   canl_bat_in, canl_gnd_in, canh_vdd_in};

  // Second stage alone feeds the logic.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= {NSYNC{1'b0}};
      sync2_q <= {NSYNC{1'b0}};
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire txd_s    = sync2_q[10];
  wire vdd_ok_s = sync2_q[9];
  wire vbat_low = sync2_q[8];
  wire wake_s   = sync2_q[7];
  wire h_dom    = sync2_q[6];
  wire l_dom    = sync2_q[5];
  wire d_dom    = sync2_q[4];
  wire h_bat    = sync2_q[3];
  wire l_bat    = sync2_q[2];
  wire l_gnd    = sync2_q[1];
  wire h_vdd    = sync2_q[0];

  //////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY.
  reg        wr_pend_q;
  reg [11:0] addr_q;
  reg [1:0]  mode_pins_q;
  wire       acc = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
    end else begin
      wr_pend_q <= acc & hwrite;
      if (acc)
        addr_q <= haddr;
    end
  end

  // Bit 1 is the standby select pin level, bit 0 the enable pin level.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_pins_q <= `MODE_CTRL_RST;
    end else if (wr_pend_q && addr_q == `MODE_CTRL_OFS) begin
      mode_pins_q <= hwdata[1:0];
    end
  end

  wire standby_select_pin = mode_pins_q[1];
  wire enable_pin         = mode_pins_q[0];

  //////////////////////////////////////////////////////////////////////////
  // Generic filter timers: one counter each for failures 3, 6, 4/7, 8, the txd timeout and the bus wake.
  localparam NT = 6;
  wire [NT-1:0]  t_cond;
  wire [NT-1:0]  t_done;
  wire [19:0]    t_lim [0:NT-1];
  reg  [2:0]     st_q;
  wire           active = (st_q == ST_NORMAL) || (st_q == ST_RXONLY);
  reg            f3_q;
  reg            f6_q;
  reg            f47_q;
  reg            f8_q;

  assign t_lim[0] = f3_q  ? 20'd`FREC_CYC  : 20'd`F3_DET_CYC;
  assign t_lim[1] = f6_q  ? 20'd`F6_REC_CYC : 20'd`F6_DET_CYC;
  assign t_lim[2] = f47_q ? 20'd`FREC_CYC  : 20'd`F478_DET_CYC;
  assign t_lim[3] = f8_q  ? 20'd`FREC_CYC  : 20'd`F478_DET_CYC;
  assign t_lim[4] = 20'd`TXD_TIMEOUT_CYC;
  assign t_lim[5] = 20'd`WAKE_CYC;

  // Conditions 0 to 3 count while the input differs from the latched state.
  assign t_cond[0] = h_bat ^ f3_q;
  assign t_cond[1] = l_bat ^ f6_q;
  assign t_cond[2] = l_gnd ^ f47_q;
  assign t_cond[3] = h_vdd ^ f8_q;
  assign t_cond[4] = ~txd_s & (st_q == ST_NORMAL);
  assign t_cond[5] = (h_dom | l_dom) & ~active;

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi = gi + 1) begin : g_tmr
      reg [19:0] cnt_q;
      // Counter clears as soon as its condition drops.
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
          cnt_q <= 20'h00000;
        else if (!t_cond[gi])
          cnt_q <= 20'h00000;
        else if (cnt_q != t_lim[gi])
          cnt_q <= cnt_q + 20'h00001;
      end
      assign t_done[gi] = t_cond[gi] && (cnt_q == t_lim[gi]);
    end
  endgenerate

  // Fault latches toggle when their filter expires. Failures 3, 4, 7, 8
  // stay watched in low-power modes; failure 6 only in active modes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f3_q  <= 1'b0;
      f6_q  <= 1'b0;
      f47_q <= 1'b0;
      f8_q  <= 1'b0;
    end else begin
      if (t_done[0])
        f3_q <= ~f3_q;
      if (t_done[1])
        f6_q <= active ? ~f6_q : 1'b0;
      if (t_done[2])
        f47_q <= ~f47_q;
      if (t_done[3])
        f8_q <= ~f8_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Edge-count comparison for failures 1, 2 and 5.
  reg       h_dom_q;
  reg       l_dom_q;
  reg [2:0] ediff_q;
  reg       edir_q;
  reg       f125_q;
  wire      h_edge = h_dom ^ h_dom_q;
  wire      l_edge = l_dom ^ l_dom_q;

  // Difference clears to zero and the flag toggles at the threshold; agreeing edges cancel.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      h_dom_q <= 1'b0;
      l_dom_q <= 1'b0;
      ediff_q <= 3'h0;
      edir_q  <= 1'b0;
      f125_q  <= 1'b0;
    end else begin
      h_dom_q <= h_dom;
      l_dom_q <= l_dom;
      if (!active) begin
        ediff_q <= 3'h0;
      end else if (h_edge != l_edge) begin
        if (ediff_q == 3'h0 || edir_q == h_edge) begin
          edir_q <= h_edge;
          if (ediff_q == 3'd`EDGE_DIFF - 3'h1) begin
            ediff_q <= 3'h0;
            f125_q  <= ~f125_q;
          end else begin
            ediff_q <= ediff_q + 3'h1;
          end
        end else begin
          ediff_q <= ediff_q - 3'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode state machine and supply handling.
  reg [19:0] gts_cnt_q;
  reg        batt_flag_q;
  reg        wake_pend_q;
  reg        txd_to_q;
  reg        wake_ref_q;
  wire       local_wake = wake_s ^ wake_ref_q;
  wire       wake_ev    = t_done[5] | local_wake;
  reg [2:0]  st_d;

  // Pins are ignored while the logic supply is low.
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_NORMAL, ST_RXONLY, ST_STBY: begin
        case ({standby_select_pin, enable_pin})
          2'b11:   st_d = ST_NORMAL;
          2'b10:   st_d = ST_RXONLY;
          2'b01:   st_d = ST_GTS;
          default: st_d = ST_STBY;
        endcase
      end
      ST_GTS: begin
        if (standby_select_pin)
          st_d = enable_pin ? ST_NORMAL : ST_RXONLY;
        else if (!enable_pin && gts_cnt_q >= 20'd`GTS_HOLD_CYC)
          st_d = ST_SLEEP;
        else if (!enable_pin)
          st_d = ST_STBY;
      end
      ST_SLEEP: begin
        if (wake_ev)
          st_d = ST_STBY;
      end
      default: st_d = ST_STBY;
    endcase
    if (!vdd_ok_s && st_q != ST_SLEEP)
      st_d = ST_STBY;
  end

  // Reset lands in standby with the battery flag set.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q        <= ST_STBY;
      gts_cnt_q   <= 20'h00000;
      batt_flag_q <= 1'b1;
      wake_pend_q <= 1'b0;
      txd_to_q    <= 1'b0;
      wake_ref_q  <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == ST_GTS && enable_pin && !standby_select_pin &&
          gts_cnt_q != 20'd`GTS_HOLD_CYC)
        gts_cnt_q <= gts_cnt_q + 20'h00001;
      else if (st_q != ST_GTS)
        gts_cnt_q <= 20'h00000;
      // Set wins over the clear on entry to normal mode.
      if (vbat_low)
        batt_flag_q <= 1'b1;
      else if (st_d == ST_NORMAL && st_q != ST_NORMAL)
        batt_flag_q <= 1'b0;
      if (!active && wake_ev)
        wake_pend_q <= 1'b1;
      else if (st_d == ST_NORMAL && st_q != ST_NORMAL)
        wake_pend_q <= 1'b0;
      // Leaving an active mode refreshes the wake reference.
      if (active)
        wake_ref_q <= wake_s;
      else if (local_wake)
        wake_ref_q <= wake_s;
      if (t_done[4])
        txd_to_q <= 1'b1;
      else if (txd_s)
        txd_to_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Driver, termination and receive path control.
  wire any_fail = f125_q | f3_q | f6_q | f47_q | f8_q;
  wire tx_ok    = (st_q == ST_NORMAL) & ~txd_s & ~txd_to_q;
  wire h_off    = f3_q | f8_q;
  wire l_off    = f6_q | f47_q;

  assign canh_drv_on   = tx_ok & ~h_off;
  assign canl_drv_on   = tx_ok & ~l_off;
  assign canh_term_on  = active & ~h_off;
  assign canl_term_vdd = active & ~l_off;
  assign canl_term_bat = ~active & ~l_off;
  assign rx_enable     = (st_q != ST_SLEEP);
  assign regulator_inhibit_out = 1'b1;
  assign regulator_inhibit_oe  = (st_q != ST_SLEEP) &&
                                 (st_q != ST_GTS);

  // Receive and error outputs are registered; wake shown low on both.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_out      <= 1'b1;
      error_flag_n <= 1'b1;
    end else begin
      if (!active)
        rxd_out <= ~wake_pend_q;
      else if (l_off)
        rxd_out <= ~h_dom;
      else if (h_off)
        rxd_out <= ~l_dom;
      else
        rxd_out <= ~d_dom;
      if (st_q == ST_NORMAL)
        error_flag_n <= ~any_fail;
      else if (st_q == ST_RXONLY)
        error_flag_n <= ~batt_flag_q;
      else
        error_flag_n <= ~wake_pend_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero.
  reg [31:0] rdata_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rdata_q <= 32'h00000000;
    else if (acc && !hwrite) begin
      case (haddr)
        `MODE_CTRL_OFS: rdata_q <= {30'h0, mode_pins_q};
        `MODE_STAT_OFS: rdata_q <= {25'h0, vdd_ok_s, txd_to_q,
                                   wake_pend_q, batt_flag_q, st_q};
        `FAIL_STAT_OFS: rdata_q <= {27'h0, f8_q, f47_q, f6_q, f3_q,
                                   f125_q};
        default:        rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // ftcan_ctrl

// File: sim/mcu_model.sv
`timescale 1ns/100ps
// Host-side model: sends a start bit and eight data bits on txd, low first.
module mcu_model #(
  parameter int BIT_CYC = 8
) (
  input  wire       hclk,
  input  wire       go,
  input  wire [7:0] frame,
  output logic      txd,
  output logic      busy
);
  logic [8:0] sh_q = 9'h1ff;
  logic [3:0] n_q  = 4'h0;
  int         c_q  = 0;
  initial txd = 1'b1;
  initial busy = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // A low level asks for dominant; idle and end of frame leave txd high.
  always @(posedge hclk) begin
    if (!busy && go) begin
      sh_q <= {frame, 1'b0};
      n_q  <= 4'h9;
      c_q  <= 0;
      busy <= 1'b1;
    end else if (busy && c_q == 0) begin
      txd  <= (n_q == 4'h0) ? 1'b1 : sh_q[0];
      sh_q <= {1'b1, sh_q[8:1]};
      busy <= (n_q != 4'h0);
      n_q  <= n_q - 4'h1;
      c_q  <= BIT_CYC - 1;
    end else if (busy) begin
      c_q <= c_q - 1;
    end
  end
endmodule // mcu_model

// File: sim/ftcan_ctrl_sva.sv
`timescale 1ns/100ps
// Port checks; the block has one clock so defaults are shared.
module ftcan_ctrl_chk (
  input wire hclk,
  input wire hresetn,
  input wire diff_dom_in,
  input wire vdd_ok_in,
  input wire rxd_out,
  input wire error_flag_n,
  input wire regulator_inhibit_out,
  input wire regulator_inhibit_oe,
  input wire canh_drv_on,
  input wire canl_drv_on,
  input wire canh_term_on,
  input wire canl_term_vdd,
  input wire canl_term_bat,
  input wire rx_enable
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  property p_inh;
    regulator_inhibit_out;
  endproperty
  a_inh: assert property (p_inh) else $error("inhibit not high");
  property p_float;
    !regulator_inhibit_oe |-> !canh_drv_on && !canl_drv_on && canl_term_bat;
  endproperty
  a_float: assert property (p_float) else $error("sleep drive");
  property p_excl;
    !(canl_term_vdd && canl_term_bat);
  endproperty
  a_excl: assert property (p_excl) else $error("both low terms");
  property p_vdd;
    !vdd_ok_in [*4] |-> ##[0:4] canl_term_bat && !canh_drv_on && !canl_drv_on;
  endproperty
  a_vdd: assert property (p_vdd) else $error("no forced standby");
  property p_rx;
    (canh_drv_on && canl_drv_on && $stable(diff_dom_in)) [*6]
      |-> rxd_out == !diff_dom_in;
  endproperty
  a_rx: assert property (p_rx) else $error("rxd not differential");
  property p_err;
    rx_enable && canl_drv_on && !canh_drv_on |-> ##[0:3] !error_flag_n;
  endproperty
  a_err: assert property (p_err) else $error("fault not flagged");
  property p_lo;
    rx_enable && !canl_term_vdd && !canl_term_bat |-> !canl_drv_on;
  endproperty
  a_lo: assert property (p_lo) else $error("low driver on");
  property p_hi;
    rx_enable && !canh_term_on |-> !canh_drv_on;
  endproperty
  a_hi: assert property (p_hi) else $error("high driver on");
  property p_pwr;
    $rose(hresetn) |-> canl_term_bat && regulator_inhibit_oe;
  endproperty
  a_pwr: assert property (p_pwr) else $error("not standby at start");
endmodule // ftcan_ctrl_chk

bind ftcan_ctrl ftcan_ctrl_chk u_chk (.hclk, .hresetn, .diff_dom_in,
  .vdd_ok_in, .rxd_out, .error_flag_n, .regulator_inhibit_out,
  .regulator_inhibit_oe, .canh_drv_on, .canl_drv_on, .canh_term_on,
  .canl_term_vdd, .canl_term_bat, .rx_enable);

// File: sim/test_fault_tolerant_can_phy_control.sv
`timescale 1ns/100ps
`include "ftcan_ctrl_regs.vh"
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_fault_tolerant_can_phy_control;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 0;
  logic [7:0]  frame = 0;
  logic        vdd_ok_in = 1, vbat_low_in = 0, wake_pin_in = 0, dv = 0;
  logic        canh_dom_in = 0, canl_dom_in = 0, diff_dom_in = 0;
  logic        canh_bat_in = 0, canl_bat_in = 0, canl_gnd_in = 0;
  logic        canh_vdd_in = 0, rd_live = 0;
  wire         hready, hresp, txd_in, rxd_out, error_flag_n, rx_enable;
  wire         regulator_inhibit_out, regulator_inhibit_oe;
  wire         canh_drv_on, canl_drv_on, canh_term_on;
  wire         canl_term_vdd, canl_term_bat;
  wire  [31:0] hrdata;
  logic [63:0] note_q[$];
  event        port_ev;
  int          n_fail = 0, checks = 0, cyc = 0;
  wire  [31:0] obs = {25'h0, error_flag_n, rxd_out, regulator_inhibit_oe,
                      canh_drv_on, canl_drv_on, canl_term_vdd, canl_term_bat};
  localparam logic [11:0] ST = `MODE_STAT_OFS;
  localparam logic [11:0] FL = `FAIL_STAT_OFS;

  ftcan_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .txd_in, .rxd_out,
    .error_flag_n, .regulator_inhibit_out, .regulator_inhibit_oe, .vdd_ok_in,
    .vbat_low_in, .wake_pin_in, .canh_dom_in, .canl_dom_in, .diff_dom_in,
    .canh_bat_in, .canl_bat_in, .canl_gnd_in, .canh_vdd_in, .canh_drv_on,
    .canl_drv_on, .canh_term_on, .canl_term_vdd, .canl_term_bat, .rx_enable);
  mcu_model u_mcu (.hclk, .go, .frame, .txd(txd_in), .busy());

  always #5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // Watchers take the oldest note as each result shows and compare.
  always @(posedge hclk) begin
    if (rd_live && hready) begin
      `CMP(hrdata & note_q[0][63:32], note_q[0][31:0])
      void'(note_q.pop_front());
    end
  end
  always @(port_ev) begin
    `CMP(obs & note_q[0][63:32], note_q[0][31:0])
    void'(note_q.pop_front());
  end

  // One AHB single transfer; the wait ends only on hready.
  task bus(input logic w, input logic [11:0] a, input logic [31:0] m,
           input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= e;
    if (!w) note_q.push_back({m, e});
    rd_live <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_live <= 1'b0;
  endtask
  // Samples off the edge, so registered outputs have landed.
  task port(input logic [31:0] m, input logic [31:0] e);
    #1;
    note_q.push_back({m, e});
    -> port_ev;
    @(posedge hclk);
  endtask
  task mode(input logic [1:0] p);
    bus(1'b1, `MODE_CTRL_OFS, 32'h0, {30'h0, p});
    repeat (8) @(posedge hclk);
  endtask
  task toggle3;
    repeat (3) begin
      canh_dom_in <= ~canh_dom_in;
      repeat (4) @(posedge hclk);
    end
    repeat (8) @(posedge hclk);
  endtask
  task conclude;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // A hang is cut short well above the expected run length.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      $display("MISMATCH %0t timeout", $time);
      conclude;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h77c3));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ST, 32'hf, 32'ha);
    port(32'h13, 32'h11);
    $display("test power_up done");
    diff_dom_in <= 1'b1;
    mode(2'h2);
    bus(1'b0, ST, 32'h7, 32'h1);
    port(32'h6e, 32'h02);
    diff_dom_in <= 1'b0;
    mode(2'h3);
    bus(1'b0, ST, 32'hf, 32'h0);
    bus(1'b0, 12'h00c, 32'hffffffff, 32'h0);
    port(32'h5f, 32'h52);
    vbat_low_in <= 1'b1;
    repeat (4) @(posedge hclk);
    vbat_low_in <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(1'b0, ST, 32'hf, 32'h8);
    $display("test modes done");
    // Three unmatched edges on the high line flag, three more recover.
    toggle3;
    bus(1'b0, FL, 32'h1, 32'h1);
    port(32'h4c, 32'h00);
    toggle3;
    bus(1'b0, FL, 32'h1, 32'h0);
    $display("test edge_count done");
    frame <= 8'($urandom);
    go <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      dv = 1'($urandom);
      diff_dom_in <= dv;
      go <= 1'b0;
      repeat (6) @(posedge hclk);
      port(32'h20, {26'h0, ~dv, 5'h0});
    end
    diff_dom_in <= 1'b0;
    $display("test receive done");
    canh_bat_in <= 1'b1;
    repeat (`F3_DET_CYC + 20) @(posedge hclk);
    canl_dom_in <= 1'b1;
    repeat (6) @(posedge hclk);
    port(32'h6c, 32'h00);
    bus(1'b0, FL, 32'h2, 32'h2);
    // An all-dominant frame shows the low driver alone left switched on.
    frame <= 8'h00;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (20) @(posedge hclk);
    port(32'h0c, 32'h04);
    repeat (80) @(posedge hclk);
    canh_bat_in <= 1'b0;
    canl_dom_in <= 1'b0;
    repeat (`FREC_CYC + 20) @(posedge hclk);
    port(32'h4c, 32'h40);
    $display("test fault3 done");
    vdd_ok_in <= 1'b0;
    repeat (6) @(posedge hclk);
    bus(1'b0, ST, 32'h47, 32'h2);
    vdd_ok_in <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(1'b0, ST, 32'h47, 32'h40);
    $display("test supply done");
    mode(2'h1);
    repeat (`GTS_HOLD_CYC + 20) @(posedge hclk);
    mode(2'h0);
    bus(1'b0, ST, 32'h7, 32'h4);
    port(32'h1d, 32'h01);
    wake_pin_in <= ~wake_pin_in;
    repeat (`WAKE_CYC + 100) @(posedge hclk);
    bus(1'b0, ST, 32'h17, 32'h12);
    port(32'h51, 32'h11);
    mode(2'h3);
    bus(1'b0, ST, 32'h1f, 32'h0);
    $display("test sleep_wake done");
    conclude;
  end
endmodule // test_fault_tolerant_can_phy_control
